// ### uebc_pkg.sv
// Shared constants and types for the endpoint buffer controller.
// Assumes one 200 MHz clock (mclk) for both ends and an active-high async reset.
package uebc_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int EP_NUM = 4;           // Generic endpoints handled
   localparam int EP_W   = 2;
   localparam int CNT_W  = 10;          // Remaining byte count width
   localparam int LEN_W  = 7;           // Packet length width, up to 64
   localparam logic [LEN_W-1:0] MAX_PKT = 7'h40;

   // ****************************************
   // Command/status entry layout
   // ****************************************
   localparam int ENT_CNT_LSB = 0;
   localparam int ENT_ACTIVE  = 10;
   localparam int ENT_HALT    = 11;
   localparam int ENT_DIS     = 12;
   localparam int ENT_TR      = 13;
   localparam int ENT_TV      = 14;
   localparam int ENT_W       = 15;
   localparam logic [ENT_W-1:0] ENT_RST = 15'h0000;

   // ****************************************
   // Controller register map (byte offsets)
   // ****************************************
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_SEL     = 8'h04;
   localparam logic [7:0] REG_ENTRY   = 8'h08;
   localparam logic [7:0] REG_INUSE   = 8'h0C;
   localparam logic [7:0] REG_SKIP    = 8'h10;
   localparam logic [7:0] REG_INTSTAT = 8'h14;
   localparam logic [7:0] REG_DEVSTAT = 8'h18;
   localparam int CTRL_FORCE   = 0;     // force_clock_request
   localparam int CTRL_WAKE    = 1;     // usb_clock_control wake enable
   localparam int CTRL_CFG_LSB = 4;     // Buffer config, one bit per endpoint
   localparam int SEL_BUF      = 2;     // Buffer select above the endpoint field
   localparam int DEV_SUSP     = 0;     // suspend_flag
   localparam int DEV_CLK      = 1;     // usb_clock_state
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [2:0]  SEL_RST  = 3'h0;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ           = 200;
   localparam int CLK_OFF_DELAY_US  = 2000;  // Clock request drop after suspend
   localparam int CLK_OFF_CYCLES    = CLK_OFF_DELAY_US * CLK_MHZ;
   localparam int CLK_CNT_W         = 20;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {RESP_NONE, RESP_ACK, RESP_NAK, RESP_STALL} uebc_resp_t;

endpackage

// ### uebc_if.sv
// Link between the endpoint engine and its software-facing controller.
// Both ends run on the same clock; all strobes are one-cycle pulses.
interface uebc_if;
   logic                              entWr;       // Write one command/status entry
   logic [uebc_pkg::EP_W-1:0]         entEp;
   logic                              entBuf;
   logic [uebc_pkg::ENT_W-1:0]        entWrData;
   logic [uebc_pkg::ENT_W-1:0]        entRdData;   // Entry at entEp/entBuf
   logic [uebc_pkg::EP_NUM-1:0]       bufCfg;      // 1 = double buffered
   logic                              inUseWr;
   logic [uebc_pkg::EP_NUM-1:0]       inUseWrData;
   logic [uebc_pkg::EP_NUM-1:0]       inUse;
   logic [uebc_pkg::EP_NUM-1:0]       skip;
   logic [uebc_pkg::EP_NUM-1:0]       intStatus;
   logic [uebc_pkg::EP_NUM-1:0]       intClear;
   logic                              forceClockRequest;
   logic                              wakeEnable;
   logic                              suspendClear;
   logic                              suspendFlag;
   logic                              clockState;

   modport dev (
      input  entWr, entEp, entBuf, entWrData, bufCfg, inUseWr, inUseWrData, skip,
             intClear, forceClockRequest, wakeEnable, suspendClear,
      output entRdData, inUse, intStatus, suspendFlag, clockState
   );
   modport ctl (
      output entWr, entEp, entBuf, entWrData, bufCfg, inUseWr, inUseWrData, skip,
             intClear, forceClockRequest, wakeEnable, suspendClear,
      input  entRdData, inUse, intStatus, suspendFlag, clockState
   );
endinterface

// ### uebc_device.sv
// Endpoint buffer engine: entries, buffer selection, handshakes, suspend and
// clock request. Faces the controller through uebc_if and the USB packet
// engine through plain ports; busSuspended comes from the pin side.
module uebc_device #(
   parameter int CLK_OFF_CYCLES = uebc_pkg::CLK_OFF_CYCLES
) (
   input  wire logic                          mclk,
   input  wire logic                          rst,
   uebc_if.dev                                link,
   input  wire logic                          tokenValid,
   input  wire logic [uebc_pkg::EP_W-1:0]     tokenEp,
   input  wire logic                          pktDone,
   input  wire logic [uebc_pkg::LEN_W-1:0]    pktLen,
   input  wire logic                          busSuspended,
   output uebc_pkg::uebc_resp_t               respCode,
   output logic                               respValid,
   output logic                               respToggle,
   output logic                               clockRequest,
   output logic                               wakeEvent
);

   // ****************************************
   // Storage and state
   // ****************************************
   localparam int CLK_CNT_W_L = uebc_pkg::CLK_CNT_W;
   localparam logic [CLK_CNT_W_L-1:0] OFF_LAST = CLK_CNT_W_L'(CLK_OFF_CYCLES - 1);

   logic [uebc_pkg::ENT_W-1:0]   entry [0:2*uebc_pkg::EP_NUM-1];
   logic [uebc_pkg::EP_NUM-1:0]  inUse;
   logic [uebc_pkg::EP_NUM-1:0]  toggle;
   logic [uebc_pkg::EP_NUM-1:0]  intStatus;
   logic [uebc_pkg::EP_W-1:0]    curEp;
   logic                         curBuf;
   logic                         curArmed;
   logic                         suspSync1;
   logic                         suspSync2;
   logic                         suspendFlag;
   logic                         clockRequestPrev;
   logic [CLK_CNT_W_L-1:0]       offCount;

   typedef enum logic [1:0] {SUS_AWAKE, SUS_WAIT, SUS_ASLEEP} uebc_sus_t;
   uebc_sus_t susState;
   uebc_sus_t next_susState;

   // ****************************************
   // Token decode
   // ****************************************
   logic                         tokBuf;
   logic [uebc_pkg::ENT_W-1:0]   tokEntry;
   logic [uebc_pkg::ENT_W-1:0]   curEntry;
   logic [uebc_pkg::CNT_W-1:0]   curCount;
   logic                         pktFinal;
   logic [uebc_pkg::CNT_W-1:0]   next_count;

   // Single buffering still follows inUse, which software may set
   assign tokBuf   = inUse[tokenEp];
   assign tokEntry = entry[{tokenEp, tokBuf}];
   assign curEntry = entry[{curEp, curBuf}];
   assign curCount = curEntry[uebc_pkg::ENT_CNT_LSB +: uebc_pkg::CNT_W];
   // Short packet or exhausted count ends the buffer
   assign pktFinal = ({3'h0, pktLen} >= curCount) || (pktLen < uebc_pkg::MAX_PKT);
   assign next_count = pktFinal ? 10'h000 : curCount - {3'h0, pktLen};

   // Handshake choice on a token
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         respValid  <= 1'b0;
         respCode   <= uebc_pkg::RESP_NONE;
         respToggle <= 1'b0;
         curEp      <= 2'h0;
         curBuf     <= 1'b0;
         curArmed   <= 1'b0;
      end else begin
         respValid <= tokenValid;
         if (tokenValid) begin
            curEp  <= tokenEp;
            curBuf <= tokBuf;
            respToggle <= tokEntry[uebc_pkg::ENT_TR] ? tokEntry[uebc_pkg::ENT_TV] : toggle[tokenEp];
            curArmed <= 1'b0;
            if (tokEntry[uebc_pkg::ENT_DIS]) begin
               respCode <= uebc_pkg::RESP_NONE;
            end else if (tokEntry[uebc_pkg::ENT_ACTIVE]) begin
               respCode <= uebc_pkg::RESP_ACK;
               curArmed <= 1'b1;
            end else if (tokEntry[uebc_pkg::ENT_HALT]) begin
               respCode <= uebc_pkg::RESP_STALL;
            end else begin
               respCode <= uebc_pkg::RESP_NAK;
            end
         end else if (pktDone) begin
            curArmed <= 1'b0;
         end
      end
   end

   // ****************************************
   // Entries: software write, packet update, skip
   // ****************************************
   // Software write goes last so it wins; software waits for inactive anyway
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 2*uebc_pkg::EP_NUM; i++) begin
            entry[i] <= uebc_pkg::ENT_RST;
         end
      end else begin
         if (tokenValid && tokEntry[uebc_pkg::ENT_TR]) begin
            entry[{tokenEp, tokBuf}][uebc_pkg::ENT_TR] <= 1'b0;
         end
         if (pktDone && curArmed) begin
            entry[{curEp, curBuf}][uebc_pkg::ENT_CNT_LSB +: uebc_pkg::CNT_W] <= next_count;
            if (pktFinal) begin
               entry[{curEp, curBuf}][uebc_pkg::ENT_ACTIVE] <= 1'b0;
            end
         end
         for (int e = 0; e < uebc_pkg::EP_NUM; e++) begin
            if (link.skip[e]) begin
               entry[{e[uebc_pkg::EP_W-1:0], inUse[e]}][uebc_pkg::ENT_ACTIVE] <= 1'b0;
            end
         end
         if (link.entWr) begin
            entry[{link.entEp, link.entBuf}] <= link.entWrData;
         end
      end
   end

   // ****************************************
   // Per-endpoint buffer in use, toggle, interrupt
   // ****************************************
   generate
      for (genvar g = 0; g < uebc_pkg::EP_NUM; g++) begin : gEp
         localparam logic [uebc_pkg::EP_W-1:0] GEP = uebc_pkg::EP_W'(g);
         logic doneHere;
         logic skipHere;
         // Skip only counts when it actually deactivates an entry
         assign doneHere = pktDone && curArmed && pktFinal && (curEp == GEP);
         assign skipHere = link.skip[g] && entry[{GEP, inUse[g]}][uebc_pkg::ENT_ACTIVE];

         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               inUse[g] <= 1'b0;
            end else if (link.inUseWr) begin
               inUse[g] <= link.inUseWrData[g];
            end else if (link.bufCfg[g] && (doneHere || skipHere)) begin
               inUse[g] <= ~inUse[g];
            end
         end

         // Toggle holds the inverse of the value used on the last answered packet
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               toggle[g] <= 1'b0;
            end else if (tokenValid && tokenEp == GEP && tokEntry[uebc_pkg::ENT_TR]) begin
               toggle[g] <= tokEntry[uebc_pkg::ENT_TV];
            end else if (pktDone && curArmed && curEp == GEP) begin
               toggle[g] <= ~respToggle;
            end
         end

         // Set wins over a clear in the same cycle
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               intStatus[g] <= 1'b0;
            end else if (doneHere) begin
               intStatus[g] <= 1'b1;
            end else if (link.intClear[g]) begin
               intStatus[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ****************************************
   // Suspend and clock request
   // ****************************************
   // Bus suspend arrives from the pin side
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         suspSync1 <= 1'b0;
         suspSync2 <= 1'b0;
      end else begin
         suspSync1 <= busSuspended;
         suspSync2 <= suspSync1;
      end
   end

   // Flag follows the bus; a software clear also forces it low (resume)
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         suspendFlag <= 1'b0;
      end else if (link.suspendClear || !suspSync2) begin
         suspendFlag <= 1'b0;
      end else begin
         suspendFlag <= 1'b1;
      end
   end

   always_comb begin
      next_susState = susState;
      case (susState)
         SUS_AWAKE:  if (suspendFlag) next_susState = SUS_WAIT;
         SUS_WAIT:   if (!suspendFlag) next_susState = SUS_AWAKE;
                     else if (offCount == OFF_LAST) next_susState = SUS_ASLEEP;
         SUS_ASLEEP: if (!suspendFlag) next_susState = SUS_AWAKE;
         default:    next_susState = SUS_AWAKE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         susState <= SUS_AWAKE;
         offCount <= '0;
      end else begin
         susState <= next_susState;
         offCount <= (susState == SUS_WAIT) ? offCount + 1'b1 : '0;
      end
   end

   // Force holds the clock on regardless of the bus
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         clockRequest     <= 1'b1;
         clockRequestPrev <= 1'b1;
         wakeEvent        <= 1'b0;
      end else begin
         clockRequest     <= link.forceClockRequest || (next_susState != SUS_ASLEEP);
         clockRequestPrev <= clockRequest;
         wakeEvent        <= link.wakeEnable && clockRequest && !clockRequestPrev;
      end
   end

   // ****************************************
   // Status back to the controller
   // ****************************************
   assign link.entRdData  = entry[{link.entEp, link.entBuf}];
   assign link.inUse      = inUse;
   assign link.intStatus  = intStatus;
   assign link.suspendFlag = suspendFlag;
   assign link.clockState = clockRequest;

endmodule // uebc_device

// ### uebc_host.sv
// Software-facing controller: classic Wishbone slave whose registers drive the
// endpoint engine over uebc_if. Software keeps the programming sequences.
module uebc_host (
   input  wire logic          mclk,
   input  wire logic          rst,
   uebc_if.ctl                link,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic [31:0]        wb_dat_o,
   output logic               wb_ack_o
);

   // ****************************************
   // Registers
   // ****************************************
   logic [31:0] ctrl;
   logic [2:0]  sel;
   logic        req;
   logic        wrFire;
   logic [31:0] rdMux;

   // One wait state, ack drops the cycle after
   assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wrFire = req && wb_we_i;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= (req && !wb_we_i) ? rdMux : 32'h0000_0000;
      end
   end

   // Control and select; only byte lane 0 matters
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl <= uebc_pkg::CTRL_RST;
         sel  <= uebc_pkg::SEL_RST;
      end else if (wrFire) begin
         if (wb_adr_i == uebc_pkg::REG_CTRL && wb_sel_i[0]) begin
            ctrl[7:0] <= wb_dat_i[7:0];
         end
         if (wb_adr_i == uebc_pkg::REG_SEL && wb_sel_i[0]) begin
            sel <= wb_dat_i[2:0];
         end
      end
   end

   // Strobes to the engine, one cycle each
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         link.entWr        <= 1'b0;
         link.entWrData    <= uebc_pkg::ENT_RST;
         link.inUseWr      <= 1'b0;
         link.inUseWrData  <= 4'h0;
         link.skip         <= 4'h0;
         link.intClear     <= 4'h0;
         link.suspendClear <= 1'b0;
      end else begin
         link.entWr        <= wrFire && wb_adr_i == uebc_pkg::REG_ENTRY && (&wb_sel_i[1:0]);
         link.entWrData    <= wb_dat_i[uebc_pkg::ENT_W-1:0];
         link.inUseWr      <= wrFire && wb_adr_i == uebc_pkg::REG_INUSE && wb_sel_i[0];
         link.inUseWrData  <= wb_dat_i[uebc_pkg::EP_NUM-1:0];
         link.skip         <= (wrFire && wb_adr_i == uebc_pkg::REG_SKIP && wb_sel_i[0])
                              ? wb_dat_i[uebc_pkg::EP_NUM-1:0] : 4'h0;
         link.intClear     <= (wrFire && wb_adr_i == uebc_pkg::REG_INTSTAT && wb_sel_i[0])
                              ? wb_dat_i[uebc_pkg::EP_NUM-1:0] : 4'h0;
         link.suspendClear <= wrFire && wb_adr_i == uebc_pkg::REG_DEVSTAT && wb_sel_i[0]
                              && !wb_dat_i[uebc_pkg::DEV_SUSP];
      end
   end

   assign link.entEp             = sel[uebc_pkg::EP_W-1:0];
   assign link.entBuf            = sel[uebc_pkg::SEL_BUF];
   assign link.bufCfg            = ctrl[uebc_pkg::CTRL_CFG_LSB +: uebc_pkg::EP_NUM];
   assign link.forceClockRequest = ctrl[uebc_pkg::CTRL_FORCE];
   assign link.wakeEnable        = ctrl[uebc_pkg::CTRL_WAKE];

   // Read mux; unmapped offsets read zero
   always_comb begin
      rdMux = 32'h0000_0000;
      case (wb_adr_i)
         uebc_pkg::REG_CTRL:    rdMux = ctrl;
         uebc_pkg::REG_SEL:     rdMux = {29'h0, sel};
         uebc_pkg::REG_ENTRY:   rdMux = {17'h0, link.entRdData};
         uebc_pkg::REG_INUSE:   rdMux = {28'h0, link.inUse};
         uebc_pkg::REG_INTSTAT: rdMux = {28'h0, link.intStatus};
         uebc_pkg::REG_DEVSTAT: rdMux = {30'h0, link.clockState, link.suspendFlag};
         default:               rdMux = 32'h0000_0000;
      endcase
   end

endmodule // uebc_host

// ### uebc_props.sv
// Checker on the engine/controller link: buffers, skip and clock request.
// Assumes one clock mclk, active-high reset rst; placed beside the link.
module uebc_props #(
   parameter int CLK_OFF_CYCLES = 20
) (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        entWr,
   input wire logic [1:0]  entEp,
   input wire logic        entBuf,
   input wire logic [14:0] entRdData,
   input wire logic [3:0]  bufCfg,
   input wire logic        inUseWr,
   input wire logic [3:0]  inUseWrData,
   input wire logic [3:0]  inUse,
   input wire logic [3:0]  skip,
   input wire logic [3:0]  intStatus,
   input wire logic        forceClockRequest,
   input wire logic        suspendFlag,
   input wire logic        clockState
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic act;
   int   flagCnt;
   int   runCnt;
   assign act = entRdData[uebc_pkg::ENT_ACTIVE];
   // Suspend time; runCnt restarts while forced, since force holds the clock
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flagCnt <= 0;
         runCnt <= 0;
      end else begin
         flagCnt <= suspendFlag ? flagCnt + 1 : 0;
         runCnt <= (suspendFlag && !forceClockRequest) ? runCnt + 1 : 0;
      end
   end
   // ****************
   // Properties
   // ****************
   sequence s_done;
      act && !entWr && skip == 4'h0 ##1 !act && $stable(entEp) && $stable(entBuf);
   endsequence
   sequence s_skip;
      skip[entEp] && !entWr && !inUseWr && act && entBuf == inUse[entEp];
   endsequence
   property p_done_int;
      s_done |-> intStatus[entEp];
   endproperty
   property p_skip_clear;
      s_skip |=> !act;
   endproperty
   property p_skip_flip;
      s_skip ##0 bufCfg[entEp] |=> inUse[entEp] != $past(inUse[entEp]);
   endproperty
   property p_inuse_wr;
      inUseWr |=> inUse == $past(inUseWrData);
   endproperty
   property p_skip_own;
      $onehot(skip) && !inUseWr |=> ((inUse ^ $past(inUse)) & ~$past(skip)) == 4'h0;
   endproperty
   property p_force_hold;
      forceClockRequest [*3] |-> clockState;
   endproperty
   property p_off_early;
      $fell(clockState) |-> flagCnt >= CLK_OFF_CYCLES - 4;
   endproperty
   property p_off_late;
      runCnt > CLK_OFF_CYCLES + 8 |-> !clockState;
   endproperty
   a_done_int: assert property (p_done_int) else $error("no interrupt at done");
   a_skip_clear: assert property (p_skip_clear) else $error("skip kept active");
   a_skip_flip: assert property (p_skip_flip) else $error("skip kept buffer");
   a_inuse_wr: assert property (p_inuse_wr) else $error("in-use write lost");
   a_skip_own: assert property (p_skip_own) else $error("skip hit other endpoint");
   a_force_hold: assert property (p_force_hold) else $error("forced request low");
   a_off_early: assert property (p_off_early) else $error("request dropped early");
   a_off_late: assert property (p_off_late) else $error("request dropped late");
endmodule // uebc_props

// ### uebc_test.sv
// Bench: controller and engine joined by uebc_if, driven over Wishbone.
// Assumes a 200 MHz mclk; a short clock-off count keeps suspend brief.
module uebc_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OFF = 20;
   logic                 mclk, rst, cyc, stb, we, tokV, pktD, susp, ack;
   logic                 respValid, respToggle, clockRequest, wakeEvent;
   logic [7:0]           adr;
   logic [31:0]          datI, datO, rdq;
   logic [1:0]           tokEp;
   logic [3:0]           sl;
   logic [6:0]           pktLen, len;
   logic [9:0]           c;
   uebc_pkg::uebc_resp_t respCode;
   int                   seed, i;
   int                   errorCnt = 0;
   int                   checked = 0;
   int                   wakeCnt = 0;
   logic [4:0]           fl [4] = '{5'h02, 5'h06, 5'h00, 5'h03};
   uebc_pkg::uebc_resp_t rs [4] = '{uebc_pkg::RESP_STALL, uebc_pkg::RESP_NONE, uebc_pkg::RESP_NAK, uebc_pkg::RESP_ACK};
   uebc_if link();
   uebc_host uebc_host_inst (.mclk(mclk), .rst(rst), .link(link), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sl), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack));
   uebc_device #(.CLK_OFF_CYCLES(OFF)) uebc_device_inst (.mclk(mclk), .rst(rst), .link(link), .tokenValid(tokV),
      .tokenEp(tokEp), .pktDone(pktD), .pktLen(pktLen), .busSuspended(susp), .respCode(respCode),
      .respValid(respValid), .respToggle(respToggle), .clockRequest(clockRequest), .wakeEvent(wakeEvent));
   uebc_props #(.CLK_OFF_CYCLES(OFF)) uebc_props_inst (.mclk(mclk), .rst(rst), .entWr(link.entWr),
      .entEp(link.entEp), .entBuf(link.entBuf), .entRdData(link.entRdData), .bufCfg(link.bufCfg),
      .inUseWr(link.inUseWr), .inUseWrData(link.inUseWrData), .inUse(link.inUse), .skip(link.skip),
      .intStatus(link.intStatus), .forceClockRequest(link.forceClockRequest), .suspendFlag(link.suspendFlag),
      .clockState(link.clockState));
   // Clock and wake pulse counter
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) if (wakeEvent === 1'b1) wakeCnt++;
   // ****************
   // Tasks
   // ****************
   function automatic logic [31:0] ent(input logic [9:0] n, input logic [4:0] f);
      return {17'h0, f, n};
   endfunction
   // Short packet or a length reaching the remaining count ends the buffer
   function automatic logic [9:0] rem(input logic [9:0] n, input logic [6:0] l);
      return (l < 7'h40 || 10'(l) >= n) ? 10'h000 : n - 10'(l);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errorCnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_of_test();
      if (errorCnt == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // One classic cycle; waits for ack under a bound, then one idle cycle
   task automatic wbAcc(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sl <= 4'hF;
      adr <= a;
      datI <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         errorCnt++;
         end_of_test();
      end
      rdq = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic arm(input logic [1:0] ep, input logic b, input logic [31:0] e);
      wbAcc(1'b1, uebc_pkg::REG_SEL, {29'h0, b, ep});
      wbAcc(1'b1, uebc_pkg::REG_ENTRY, e);
   endtask
   task automatic tok(input logic [1:0] ep, input uebc_pkg::uebc_resp_t r);
      tokV <= 1'b1;
      tokEp <= ep;
      @(posedge mclk);
      tokV <= 1'b0;
      @(posedge mclk);
      chk("respValid", 32'h1, {31'h0, respValid});
      chk("respCode", {30'h0, r}, {30'h0, respCode});
   endtask
   task automatic pkt(input logic [6:0] n);
      pktD <= 1'b1;
      pktLen <= n;
      @(posedge mclk);
      pktD <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
      wbAcc(1'b0, a, 32'h0);
      chk(nm, e, rdq);
   endtask
   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      do begin
         wbAcc(1'b0, uebc_pkg::REG_DEVSTAT, 32'h0);
         n++;
      end while ((rdq & m) !== v && n < 100);
      chk("devstat", v, rdq & m);
      // A poll that ran out of tries has already counted its mismatch
      if ((rdq & m) !== v) begin
         end_of_test();
      end
   endtask
   // ****************
   // Main sequence
   // ****************
   initial begin
      {rst, cyc, stb, we, tokV, pktD, susp} = 7'h40;
      {adr, datI, tokEp, pktLen, sl} = '0;
      seed = 32'hB83CD551;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rdChk("devstat", uebc_pkg::REG_DEVSTAT, 32'h2);
      rdChk("unmapped", 8'h20, 32'h0);
      // Random-length single-buffered transfer, full packets then a tail
      c = 10'h041 + 10'($random(seed) & 32'h0000_00FF);
      arm(2'h1, 1'b0, ent(c, 5'h01));
      for (i = 0; i < 8 && c != 10'h000; i++) begin
         tok(2'h1, uebc_pkg::RESP_ACK);
         len = c > 10'h040 ? 7'h40 : c[6:0];
         pkt(len);
         c = rem(c, len);
         rdChk("entry", uebc_pkg::REG_ENTRY, ent(c, {4'h0, c != 10'h000}));
      end
      rdChk("intstat", uebc_pkg::REG_INTSTAT, 32'h2);
      for (i = 0; i < 4; i++) begin
         arm(2'h1, 1'b0, ent(10'h005, fl[i]));
         tok(2'h1, rs[i]);
      end
      pkt(7'h05);
      for (i = 0; i < 2; i++) begin
         arm(2'h1, 1'b0, ent(10'h005, {i[0], 4'h9}));
         tok(2'h1, uebc_pkg::RESP_ACK);
         chk("respToggle", 32'(i), {31'h0, respToggle});
         pkt(7'h05);
      end
      // Double buffering on endpoint 2
      wbAcc(1'b1, uebc_pkg::REG_CTRL, 32'h40);
      arm(2'h2, 1'b0, ent(10'h040, 5'h01));
      arm(2'h2, 1'b1, ent(10'h040, 5'h01));
      tok(2'h2, uebc_pkg::RESP_ACK);
      pkt(7'h40);
      rdChk("inuse", uebc_pkg::REG_INUSE, 32'h4);
      tok(2'h2, uebc_pkg::RESP_ACK);
      wbAcc(1'b1, uebc_pkg::REG_INUSE, 32'h0);
      tok(2'h2, uebc_pkg::RESP_NAK);
      wbAcc(1'b1, uebc_pkg::REG_INTSTAT, 32'hF);
      wbAcc(1'b1, uebc_pkg::REG_INUSE, 32'h4);
      wbAcc(1'b1, uebc_pkg::REG_SKIP, 32'h4);
      rdChk("entry", uebc_pkg::REG_ENTRY, ent(10'h040, 5'h00));
      rdChk("inuse", uebc_pkg::REG_INUSE, 32'h0);
      rdChk("intstat", uebc_pkg::REG_INTSTAT, 32'h0);
      // Halt both buffers, then unhalt; the reload must beat the running toggle of 1
      arm(2'h2, 1'b0, ent(10'h005, 5'h02));
      arm(2'h2, 1'b1, ent(10'h005, 5'h02));
      tok(2'h2, uebc_pkg::RESP_STALL);
      arm(2'h2, 1'b0, ent(10'h005, 5'h00));
      arm(2'h2, 1'b1, ent(10'h005, 5'h00));
      rdChk("inuse", uebc_pkg::REG_INUSE, 32'h0);
      arm(2'h2, 1'b0, ent(10'h005, 5'h09));
      tok(2'h2, uebc_pkg::RESP_ACK);
      chk("respToggle", 32'h0, {31'h0, respToggle});
      pkt(7'h05);
      // Suspend, clock drop, then remote wake
      wbAcc(1'b1, uebc_pkg::REG_CTRL, 32'h42);
      susp <= 1'b1;
      poll(32'h1, 32'h1);
      poll(32'h3, 32'h1);
      wbAcc(1'b1, uebc_pkg::REG_CTRL, 32'h43);
      poll(32'h2, 32'h2);
      chk("wakeCnt", 32'h1, 32'(wakeCnt));
      susp <= 1'b0;
      wbAcc(1'b1, uebc_pkg::REG_DEVSTAT, 32'h0);
      poll(32'h1, 32'h0);
      wbAcc(1'b1, uebc_pkg::REG_CTRL, 32'h40);
      poll(32'h3, 32'h2);
      end_of_test();
   end
endmodule // uebc_test
